// >>> pfls_fifo.sv
// Module: parameterised synchronous FIFO with valid and ready on both sides
`timescale 1ns/10ps
module pfls_fifo
  import pfls_pkg::*;
#(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;

  wire do_wr = in_valid && in_ready;
  wire do_rd = out_valid && out_ready;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (ce && do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (ce) begin
      if (do_wr) wr_ptr <= wr_ptr + 1'b1;
      if (do_rd) rd_ptr <= rd_ptr + 1'b1;
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule

// >>> pfls_lvds_rx.sv
// Receiver model that rebuilds 12-bit packets from the serial line
`timescale 1ns/10ps
module pfls_lvds_rx
  import pfls_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic        line_in,
  output logic             rx_valid,
  output logic      [10:0] rx_word
);
  // ----------------------------------------------------------------
  // Capture: a bit is new only after an enabled clock
  // ----------------------------------------------------------------
  logic        ce_q;
  logic [3:0]  cnt;
  logic [10:0] sh;
  always_ff @(posedge clk) begin
    ce_q     <= ce;
    rx_valid <= 1'b0;
    if (srst) begin
      cnt <= 4'h0;
    end else if (ce_q) begin
      if (cnt == 4'h0) begin
        cnt <= {3'h0, line_in};
      end else begin
        sh  <= {line_in, sh[10:1]};
        cnt <= cnt + 4'h1;
        if (cnt == 4'hb) begin
          rx_valid <= 1'b1;
          rx_word  <= {line_in, sh[10:1]};
          cnt      <= 4'h0;
        end
      end
    end
  end
endmodule

// >>> pfls_pkg.sv
// Package: constants and types for the pixel format and serializer block
package pfls_pkg;

  // ----------------------------------------------------------------
  // Conversion modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PFLS_PASS     = 3'b000,
    PFLS_BT601    = 3'b001,
    PFLS_SRGB_YCC = 3'b010,
    PFLS_SRGB_YUV = 3'b011,
    PFLS_RGB565   = 3'b100,
    PFLS_RAW10    = 3'b101,
    PFLS_BT656    = 3'b110
  } pfls_mode_e;

  typedef enum logic [1:0] {
    PFLS_IDLE = 2'b00,
    PFLS_SEND = 2'b01
  } pfls_ser_e;

  // ----------------------------------------------------------------
  // Fixed point coefficients, scaled by 2^10
  // ----------------------------------------------------------------
  localparam int PFLS_FRAC = 10;
  localparam logic signed [17:0] PFLS_K601_R  = 18'sd306;   // 0.299
  localparam logic signed [17:0] PFLS_K601_G  = 18'sd601;   // 0.587
  localparam logic signed [17:0] PFLS_K601_B  = 18'sd117;   // 0.114
  localparam logic signed [17:0] PFLS_K601_U  = 18'sd578;   // 0.564
  localparam logic signed [17:0] PFLS_K601_V  = 18'sd730;   // 0.713
  localparam logic signed [17:0] PFLS_KSRG_R  = 18'sd218;   // 0.2126
  localparam logic signed [17:0] PFLS_KSRG_G  = 18'sd732;   // 0.7152
  localparam logic signed [17:0] PFLS_KSRG_B  = 18'sd74;    // 0.0722
  localparam logic signed [17:0] PFLS_KSRG_U  = 18'sd552;   // 0.5389
  localparam logic signed [17:0] PFLS_KSRG_V  = 18'sd650;   // 0.635
  localparam logic signed [17:0] PFLS_KY_SCL  = 18'sd876;   // 219/256
  localparam logic signed [17:0] PFLS_KC_SCL  = 18'sd896;   // 224/256
  localparam logic signed [17:0] PFLS_KI_RV   = 18'sd1613;  // 1.5748
  localparam logic signed [17:0] PFLS_KI_GU   = 18'sd192;   // 0.1873
  localparam logic signed [17:0] PFLS_KI_GV   = 18'sd479;   // 0.4681
  localparam logic signed [17:0] PFLS_KI_BU   = 18'sd1900;  // 1.8556
  localparam logic signed [17:0] PFLS_OFS_C   = 18'sd128;
  localparam logic signed [17:0] PFLS_OFS_Y   = 18'sd16;

  // ----------------------------------------------------------------
  // Packet layout and serial timing
  // ----------------------------------------------------------------
  localparam int PFLS_PKT_W     = 12;
  localparam int PFLS_POS_START = 0;
  localparam int PFLS_POS_DATA  = 1;
  localparam int PFLS_POS_ROW   = 9;
  localparam int PFLS_POS_FRAME = 10;
  localparam int PFLS_POS_STOP  = 11;
  localparam logic PFLS_START_BIT = 1'b1;
  localparam logic PFLS_STOP_BIT  = 1'b0;
  localparam int PFLS_BIT_RATIO = 12;
  localparam int PFLS_PIX_MHZ   = 22;
  localparam int PFLS_SER_MHZ   = PFLS_PIX_MHZ * PFLS_BIT_RATIO;
  localparam logic [3:0] PFLS_LAST_BIT = 4'hb;

  // ----------------------------------------------------------------
  // Buffer shape and reset values
  // ----------------------------------------------------------------
  localparam int PFLS_FIFO_W = 10;
  localparam int PFLS_FIFO_D = 16;
  localparam logic [11:0] PFLS_PKT_RST = 12'h000;

endpackage

// >>> pfls_serializer.sv
// Module: pixel format conversion, byte ordering and 12-bit packet serializer
`timescale 1ns/10ps
module pfls_serializer
  import pfls_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire logic [2:0] mode_select,
  input  wire logic       chroma_offset_off,
  input  wire logic       chroma_swap,
  input  wire logic       luma_chroma_swap,
  input  wire logic       progressive_output_select,
  input  wire logic [7:0] in_y0,
  input  wire logic [7:0] in_y1,
  input  wire logic [7:0] in_u,
  input  wire logic [7:0] in_v,
  input  wire logic [9:0] in_raw,
  input  wire logic       in_row_active,
  input  wire logic       in_frame_active,
  input  wire logic       in_valid,
  output logic            in_ready,
  output logic            serial_out,
  output logic            serial_active,
  output logic            mode_error
);

  // ----------------------------------------------------------------
  // Colour arithmetic
  // ----------------------------------------------------------------
  function automatic logic [7:0] clip8(input logic signed [35:0] v);
    logic signed [35:0] s;
    s = v >>> PFLS_FRAC;
    if (s < 0) clip8 = 8'h00;
    else if (s > 36'sd255) clip8 = 8'hff;
    else clip8 = s[7:0];
  endfunction

  function automatic logic signed [35:0] sx(input logic [7:0] v);
    sx = 36'($signed({1'b0, v}));
  endfunction

  wire pfls_mode_e mode = pfls_mode_e'(mode_select);
  // Legal when the mode code is defined; BT656 also needs the progressive select
  wire mode_bad = (mode_select == 3'b111) ||
                  (mode == PFLS_BT656 && !progressive_output_select);

  // Source RGB is rebuilt from the incoming YUV
  wire signed [35:0] du = sx(in_u) - 36'(PFLS_OFS_C);
  wire signed [35:0] dv = sx(in_v) - 36'(PFLS_OFS_C);
  wire signed [35:0] y0s = sx(in_y0) <<< PFLS_FRAC;
  wire [7:0] rgb_r = clip8(y0s + 36'(PFLS_KI_RV) * dv);
  wire [7:0] rgb_g = clip8(y0s - 36'(PFLS_KI_GU) * du - 36'(PFLS_KI_GV) * dv);
  wire [7:0] rgb_b = clip8(y0s + 36'(PFLS_KI_BU) * du);

  wire is_srgb = (mode == PFLS_SRGB_YCC) || (mode == PFLS_SRGB_YUV);
  wire signed [35:0] kr = is_srgb ? 36'(PFLS_KSRG_R) : 36'(PFLS_K601_R);
  wire signed [35:0] kg = is_srgb ? 36'(PFLS_KSRG_G) : 36'(PFLS_K601_G);
  wire signed [35:0] kb = is_srgb ? 36'(PFLS_KSRG_B) : 36'(PFLS_K601_B);
  wire signed [35:0] ku = is_srgb ? 36'(PFLS_KSRG_U) : 36'(PFLS_K601_U);
  wire signed [35:0] kv = is_srgb ? 36'(PFLS_KSRG_V) : 36'(PFLS_K601_V);

  // Luma and colour differences in Q10
  wire signed [35:0] luma = kr * sx(rgb_r) + kg * sx(rgb_g) + kb * sx(rgb_b);
  wire signed [35:0] db   = (sx(rgb_b) <<< PFLS_FRAC) - luma;
  wire signed [35:0] dr   = (sx(rgb_r) <<< PFLS_FRAC) - luma;
  wire signed [35:0] cb_f = (ku * db) >>> PFLS_FRAC;
  wire signed [35:0] cr_f = (kv * dr) >>> PFLS_FRAC;

  // Video range scaling for sRGB YCbCr
  wire signed [35:0] y_ycc  = ((luma * 36'(PFLS_KY_SCL)) >>> PFLS_FRAC)
                              + (36'(PFLS_OFS_Y) <<< PFLS_FRAC);
  wire signed [35:0] cb_ycc = (cb_f * 36'(PFLS_KC_SCL)) >>> PFLS_FRAC;
  wire signed [35:0] cr_ycc = (cr_f * 36'(PFLS_KC_SCL)) >>> PFLS_FRAC;

  // Offset drop applies only to the full-range modes
  wire               ofs_on = (mode == PFLS_SRGB_YCC) || !chroma_offset_off;
  wire signed [35:0] c_ofs  = ofs_on ? (36'(PFLS_OFS_C) <<< PFLS_FRAC) : 36'sd0;

  wire               ycc   = (mode == PFLS_SRGB_YCC);
  wire [7:0]         cv_y  = clip8(ycc ? y_ycc : luma);
  wire [7:0]         cv_cb = clip8((ycc ? cb_ycc : cb_f) + c_ofs);
  wire [7:0]         cv_cr = clip8((ycc ? cr_ycc : cr_f) + c_ofs);

  wire conv = (mode == PFLS_BT601) || is_srgb;
  // Second luma follows the first in converted modes; a per-pixel pipe would cost a second datapath
  wire [7:0] o_y0 = conv ? cv_y  : in_y0;
  wire [7:0] o_y1 = conv ? cv_y  : in_y1;
  wire [7:0] o_cb = conv ? cv_cb : in_u;
  wire [7:0] o_cr = conv ? cv_cr : in_v;

  // ----------------------------------------------------------------
  // Byte ordering
  // ----------------------------------------------------------------
  wire [7:0] c_a = chroma_swap ? o_cr : o_cb;
  wire [7:0] c_b = chroma_swap ? o_cb : o_cr;
  wire [31:0] yc_word = luma_chroma_swap ? {o_y0, c_a, o_y1, c_b}
                                         : {c_a, o_y0, c_b, o_y1};

  wire [7:0]  red   = chroma_swap ? rgb_b : rgb_r;
  wire [7:0]  blue  = chroma_swap ? rgb_r : rgb_b;
  wire [7:0]  rgb_o = {red[7:3], rgb_g[7:5]};
  wire [7:0]  rgb_e = {rgb_g[4:2], blue[7:3]};
  wire [15:0] rgb_word = luma_chroma_swap ? {rgb_e, rgb_o} : {rgb_o, rgb_e};

  wire [15:0] raw_word = {in_raw[9:2], 6'h00, in_raw[1:0]};

  wire [2:0] nbytes = (mode == PFLS_RGB565 || mode == PFLS_RAW10) ? 3'h2 : 3'h4;
  wire [31:0] word = (mode == PFLS_RGB565) ? {rgb_word, 16'h0000} :
                     (mode == PFLS_RAW10)  ? {raw_word, 16'h0000} : yc_word;

  // ----------------------------------------------------------------
  // Byte splitter into FIFO
  // ----------------------------------------------------------------
  logic [31:0] hold_word;
  logic [2:0]  hold_left;
  logic [1:0]  hold_flags;
  logic        f_in_ready;
  logic [9:0]  f_out_data;
  logic        f_out_valid;
  logic        f_out_ready;

  wire        hold_busy = (hold_left != 3'h0);
  wire        take      = in_valid && !hold_busy && !mode_bad;
  // Ready returns while a request waits, so a held in_valid cannot lock the port
  wire        accept    = take && in_ready;
  wire        push      = hold_busy && f_in_ready;
  wire [9:0]  push_data = {hold_flags, hold_word[31:24]};

  always_ff @(posedge clk) begin
    if (srst) begin
      hold_word  <= 32'h00000000;
      hold_left  <= 3'h0;
      hold_flags <= 2'h0;
      in_ready   <= 1'b0;
      mode_error <= 1'b0;
    end else if (ce) begin
      in_ready   <= !hold_busy && !accept && !mode_bad;
      mode_error <= mode_bad;
      if (accept) begin
        hold_word  <= word;
        hold_left  <= nbytes;
        hold_flags <= {in_frame_active, in_row_active};
      end else if (push) begin
        hold_word <= {hold_word[23:0], 8'h00};
        hold_left <= hold_left - 3'h1;
      end
    end
  end

  pfls_fifo #(
    .WIDTH(PFLS_FIFO_W),
    .DEPTH(PFLS_FIFO_D)
  ) pfls_fifo_inst (
    .clk       (clk),
    .srst      (srst),
    .ce        (ce),
    .in_data   (push_data),
    .in_valid  (hold_busy),
    .in_ready  (f_in_ready),
    .out_data  (f_out_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready)
  );

  // ----------------------------------------------------------------
  // Serializer; clk stands for the bit clock, twelve per pixel period
  // ----------------------------------------------------------------
  pfls_ser_e   ser_state;
  logic [11:0] shreg;
  logic [3:0]  bit_cnt;

  wire last_bit = (bit_cnt == PFLS_LAST_BIT);
  wire [11:0] next_packet = {PFLS_STOP_BIT, f_out_data[9], f_out_data[8],
                             f_out_data[7:0], PFLS_START_BIT};
  assign f_out_ready = ce && ((ser_state == PFLS_IDLE) || last_bit);

  always_ff @(posedge clk) begin
    if (srst) begin
      ser_state     <= PFLS_IDLE;
      shreg         <= PFLS_PKT_RST;
      bit_cnt       <= 4'h0;
      serial_out    <= PFLS_STOP_BIT;
      serial_active <= 1'b0;
    end else if (ce) begin
      unique case (ser_state)
        PFLS_IDLE: begin
          serial_out <= PFLS_STOP_BIT;
          if (f_out_valid) begin
            ser_state     <= PFLS_SEND;
            shreg         <= next_packet;
            bit_cnt       <= 4'h0;
            serial_active <= 1'b1;
          end
        end
        PFLS_SEND: begin
          serial_out <= shreg[bit_cnt];
          bit_cnt    <= bit_cnt + 4'h1;
          if (last_bit) begin
            bit_cnt <= 4'h0;
            if (f_out_valid) begin
              shreg <= next_packet;
            end else begin
              ser_state     <= PFLS_IDLE;
              serial_active <= 1'b0;
            end
          end
        end
      endcase
    end
  end
endmodule

// >>> pfls_serializer_bench.sv
// Self-checking bench for the serializer block
`timescale 1ns/10ps
module pfls_serializer_bench
  import pfls_pkg::*;
();
  logic        clk, srst, ce, cs, ls, off, prog, in_valid, row, frame, ce_on;
  logic        in_ready, sout, sact, merr, rx_valid;
  logic [2:0]  mode;
  logic [7:0]  y0, y1, u, v;
  logic [9:0]  raw;
  logic [10:0] rx_word;
  logic [10:0] expq[$];
  logic [31:0] rnd;
  logic [31:0] crnd = 32'd9793;
  int          fails, comparisons;
  pfls_serializer pfls_serializer_inst (
    .clk(clk), .srst(srst), .ce(ce), .mode_select(mode), .chroma_offset_off(off),
    .chroma_swap(cs), .luma_chroma_swap(ls), .progressive_output_select(prog),
    .in_y0(y0), .in_y1(y1), .in_u(u), .in_v(v), .in_raw(raw), .in_row_active(row),
    .in_frame_active(frame), .in_valid(in_valid), .in_ready(in_ready),
    .serial_out(sout), .serial_active(sact), .mode_error(merr)
  );
  pfls_lvds_rx pfls_lvds_rx_inst (
    .clk(clk), .srst(srst), .ce(ce), .line_in(sout), .rx_valid(rx_valid), .rx_word(rx_word)
  );
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (fails == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!(in_ready === 1'b1 && ce === 1'b1) && n < 400);
    if (n >= 400) begin
      fails++;
      results();
    end
  endtask
  // Gray input keeps the conversions exact, so rounding cannot hide a wrong matrix
  task automatic send();
    logic [2:0]  md;
    logic        c, l, ps;
    logic [7:0]  a0, yy, cc, c1, c2, ye, b[4];
    logic [31:0] r2;
    int          nb;
    rnd = xs(rnd);
    r2 = xs(rnd);
    md = rnd[2:0] % 3'h7;
    ps = (md == 3'h0) || (md == 3'h6);
    c = rnd[19] && md != 3'h5;
    l = rnd[20] && md != 3'h5;
    a0 = (md == 3'h2) ? 8'h00 : rnd[10:3];
    yy = (md == 3'h2) ? 8'h10 : a0;
    cc = (rnd[21] && md != 3'h2) ? 8'h00 : 8'h80;
    c1 = ps ? (c ? r2[7:0] : r2[15:8]) : cc;
    c2 = ps ? (c ? r2[15:8] : r2[7:0]) : cc;
    ye = ps ? rnd[18:11] : yy;
    if (l) b = '{yy, c1, ye, c2};
    else b = '{c1, yy, c2, ye};
    if (md == 3'h4) begin
      b[l] = {a0[7:3], a0[7:5]};
      b[!l] = {a0[4:2], a0[7:3]};
    end
    if (md == 3'h5) begin
      b[0] = rnd[31:24];
      b[1] = {6'h00, rnd[23:22]};
    end
    nb = (md == 3'h4 || md == 3'h5) ? 2 : 4;
    for (int i = 0; i < nb; i++) expq.push_back({1'b0, r2[17], r2[16], b[i]});
    wait_ready();
    {mode, off, cs, ls, row, frame} <= {md, rnd[21], c, l, r2[16], r2[17]};
    {y0, y1, raw} <= {a0, rnd[18:11], rnd[31:22]};
    {u, v} <= ps ? r2[15:0] : 16'h8080;
    in_valid <= 1'b1;
    wait_ready();
    in_valid <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // Clock, enable stalls and result watcher
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    crnd = xs(crnd);
    ce <= !ce_on || crnd[2:0] != 3'h0;
  end
  always @(posedge clk) begin
    if (rx_valid === 1'b1) begin
      if (expq.size() == 0) check(rx_word, 11'h7ff);
      else check(rx_word, expq.pop_front());
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    {srst, prog, in_valid, mode, cs, ls, off, row, frame, ce_on} = 12'hc00;
    {y0, y1, u, v, raw} = 42'h0;
    rnd = 32'd9793;
    fails = 0;
    comparisons = 0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 120; i++) begin
      if (i == 60) ce_on <= 1'b1;
      send();
    end
    ce_on <= 1'b0;
    n = 0;
    while ((expq.size() != 0 || sact !== 1'b0) && n < 3000) begin
      @(posedge clk);
      n++;
    end
    check({10'h0, expq.size() == 0 && n < 3000}, 11'h1);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      mode <= (k == 0) ? 3'h7 : 3'h6;
      prog <= k == 2;
      in_valid <= k != 2;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (merr !== (k != 2) && n < 8);
      check({10'h0, merr}, {10'h0, k != 2});
      if (k != 2) check({10'h0, in_ready}, 11'h0);
    end
    in_valid <= 1'b0;
    mode <= 3'h0;
    repeat (2) @(posedge clk);
    results();
  end
endmodule

// >>> pfls_serializer_monitor.sv
// Checker for the serializer block ports, with its bind
`timescale 1ns/10ps
module pfls_serializer_chk
  import pfls_pkg::*;
(
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       ce,
  input wire logic [2:0] mode_select,
  input wire logic       progressive_output_select,
  input wire logic       in_valid,
  input wire logic       in_ready,
  input wire logic       serial_out,
  input wire logic       serial_active,
  input wire logic       mode_error
);
  // ----------------------------------------------------------------
  // Packet phase: 1 marks the start bit, 12 the stop bit
  // ----------------------------------------------------------------
  logic [3:0] ph;
  wire        bad  = mode_select == 3'h7 || (mode_select == 3'h6 && !progressive_output_select);
  wire        take = ce && in_valid && in_ready && !bad;
  // Phase only moves with ce, so frozen cycles keep it aligned with the line
  always_ff @(posedge clk) begin
    if (srst) ph <= 4'h0;
    else if (ce) ph <= !serial_active ? 4'h0 : (ph == 4'hc ? 4'h1 : ph + 4'h1);
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_rst;
    disable iff (1'b0) srst && ce |=> !in_ready && !serial_out && !serial_active && !mode_error;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_take; take |=> !in_ready [*2]; endproperty
  a_take: assert property (p_take) else $error("ready back too early");
  property p_refuse; ce && bad && $past(bad) |=> mode_error && !in_ready; endproperty
  a_refuse: assert property (p_refuse) else $error("illegal mode accepted");
  property p_legal; ce && !bad && !$past(bad) |=> !mode_error; endproperty
  a_legal: assert property (p_legal) else $error("legal mode flagged");
  property p_idle; !serial_active |-> !serial_out; endproperty
  a_idle: assert property (p_idle) else $error("line not low when idle");
  property p_start; serial_active && ph == 4'h1 |-> serial_out; endproperty
  a_start: assert property (p_start) else $error("start bit missing");
  property p_stop; ph == 4'hc |-> !serial_out; endproperty
  a_stop: assert property (p_stop) else $error("stop bit not low");
  // Active drops on the edge that puts the stop bit out, so only phases 0 to 10 must hold it
  property p_gap; ce && serial_active && ph < 4'hb |=> serial_active; endproperty
  a_gap: assert property (p_gap) else $error("packet cut short");
  property p_frz; !ce |=> $stable(serial_out) && $stable(serial_active) && $stable(in_ready);
  endproperty
  a_frz: assert property (p_frz) else $error("state moved without ce");
  c_take: cover property (take);
  c_refuse: cover property (bad && mode_error);
  c_b2b: cover property (ph == 4'hc && serial_active ##1 serial_active && ph == 4'h1);
  c_frz: cover property (!ce && serial_active);
endmodule
bind pfls_serializer pfls_serializer_chk pfls_serializer_chk_inst (
  .clk(clk), .srst(srst), .ce(ce), .mode_select(mode_select),
  .progressive_output_select(progressive_output_select), .in_valid(in_valid),
  .in_ready(in_ready), .serial_out(serial_out), .serial_active(serial_active),
  .mode_error(mode_error)
);
